//--- conveyor_pkg.sv
// Constants, types and register map for the carrier conveyor motion controller
//
// How it works
// R1 - Recall drives inward, stops at inside limit
// R2 - Car send drives out, stops at car limit
// R3 - Truck send drives out, stops at truck limit
// R4 - One car/truck hop, then recall required
// R5 - Separate outward, inward shift and high-duration settings
// R6 - Shift points counted in sprocket rotation pulses
// R7 - Config switch selects long or short high range
// R8 - 45 second run limit stops the motor
// R9 - Operator holds car and truck at power-up
// R10 - Both held at power-up starts autocycling
// R11 - Power press ends autocycle, unit off
// R12 - Brake released only when powered or manually
// R13 - Power switch indicator follows the button only
// R14 - Limit indicators lit; no move toward active limit
// R15 - Recall or customer start lights recall, moves in
// R16 - Car and truck buttons light their indicators
// R17 - Power press toggles on/off; moves only when on
// R18 - Rotation indicator follows sprocket pulse input
// R19 - Motor drive needs brake-released confirmation
// R20 - Low, high at shift count, low after duration
// R21 - Commands ignored mid-move; stop at target limit
package conveyor_pkg;

    localparam longint unsigned CLK_HZ = 125_000_000;
    localparam longint unsigned RUN_LIMIT_S = 45;
    localparam longint unsigned RUN_LIMIT_CYC = RUN_LIMIT_S * CLK_HZ;
    localparam int RUN_CNT_W = 33;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SEND_SHIFT = 8'h04;
    localparam logic [7:0] OFS_RECALL_SHIFT = 8'h08;
    localparam logic [7:0] OFS_HIGH_COUNT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLR_FAULT_BIT = 1;
    localparam logic CTRL_ENABLE_RST = 1'b1;

    localparam int SET_W = 16;
    localparam logic [SET_W-1:0] SEND_SHIFT_RST = 16'h0040;
    localparam logic [SET_W-1:0] RECALL_SHIFT_RST = 16'h0040;
    localparam logic [SET_W-1:0] HIGH_COUNT_RST = 16'h0080;
    localparam int LONG_RANGE_SHIFT = 2;

    localparam logic [2:0] STRAP_WAIT_CYC = 3'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_CAR, DIR_TRUCK} target_e;

    typedef struct packed {
        logic cfg_long;
        logic brake_ok;
        logic brake_manual;
        logic rot_pulse;
        logic lim_truck;
        logic lim_car;
        logic lim_inside;
        logic power_btn;
        logic truck_btn;
        logic car_btn;
        logic cust_start;
        logic recall_btn;
    } panel_in_s;

    typedef struct packed {
        logic brake_manual_indicator;
        logic rotation_indicator;
        logic truck_stop_limit_indicator;
        logic car_stop_limit_indicator;
        logic inside_stop_limit_indicator;
        logic truck_send_indicator;
        logic car_send_indicator;
        logic inward_request_indicator;
        logic power_on_indicator;
        logic power_switch_indicator;
    } panel_ind_s;

endpackage

//--- input_sync.sv
// Two-stage synchroniser with rising-edge pulse for a bank of pin inputs
`timescale 1ns/100ps
module input_sync #(
    parameter int WIDTH = 12
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] prev_q;

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    meta_q[b] <= 1'b0;
                    level_q[b] <= 1'b0;
                    prev_q[b] <= 1'b0;
                end else begin
                    meta_q[b] <= i_pin[b];
                    level_q[b] <= meta_q[b];
                    prev_q[b] <= level_q[b];
                end
            end
            assign o_rise[b] = level_q[b] & ~prev_q[b];
        end
    endgenerate

    assign o_level = level_q;
endmodule // input_sync

//--- carrier_conveyor_motion_control.sv
// Carrier conveyor motion controller with AXI4-Lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module carrier_conveyor_motion_control #(
    parameter logic [conveyor_pkg::RUN_CNT_W-1:0] RUN_LIMIT_CYCLES =
        conveyor_pkg::RUN_CNT_W'(conveyor_pkg::RUN_LIMIT_CYC)
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire conveyor_pkg::panel_in_s i_panel,
    output conveyor_pkg::panel_ind_s o_ind,
    output logic o_motor_run,
    output logic o_motor_high,
    output logic o_motor_dir_out,
    output logic o_brake_release,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    typedef enum logic [1:0] {ST_STARTUP, ST_IDLE, ST_MOVE} state_e;
    typedef enum logic [1:0] {PH_LOW_PRE, PH_HIGH, PH_LOW_POST} phase_e;

    localparam int SW = conveyor_pkg::SET_W;
    localparam int HW = SW + conveyor_pkg::LONG_RANGE_SHIFT;

    conveyor_pkg::panel_in_s lvl;
    conveyor_pkg::panel_in_s rise;

    input_sync #(.WIDTH($bits(conveyor_pkg::panel_in_s))) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(i_panel),
        .o_level(lvl),
        .o_rise(rise)
    );

    state_e state_q, state_d;
    phase_e phase_q, phase_d;
    conveyor_pkg::target_e target_q, target_d;
    logic power_q, power_d;
    logic auto_q, auto_d;
    logic hop_used_q, hop_used_d;
    logic fault_q, fault_d;
    logic [2:0] strap_q;
    logic [HW-1:0] rot_cnt_q, rot_cnt_d;
    logic [conveyor_pkg::RUN_CNT_W-1:0] run_cnt_q, run_cnt_d;

    logic ctrl_en_q;
    logic [SW-1:0] send_shift_q;
    logic [SW-1:0] recall_shift_q;
    logic [SW-1:0] high_count_q;

    logic wr_go, wr_fire, rd_go, rd_fire;
    logic wr_sel_ctrl, wr_sel_send, wr_sel_recall, wr_sel_high, wr_mapped;
    logic rd_mapped;
    logic clr_fault;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    assign wr_go = i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
    assign wr_fire = o_awready;
    assign rd_go = i_arvalid & ~o_arready & ~o_rvalid;
    assign rd_fire = o_arready;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_strb
            assign wmask[8*g +: 8] = {8{i_wstrb[g]}};
        end
    endgenerate

    assign wr_sel_ctrl = (i_awaddr == conveyor_pkg::OFS_CTRL);
    assign wr_sel_send = (i_awaddr == conveyor_pkg::OFS_SEND_SHIFT);
    assign wr_sel_recall = (i_awaddr == conveyor_pkg::OFS_RECALL_SHIFT);
    assign wr_sel_high = (i_awaddr == conveyor_pkg::OFS_HIGH_COUNT);
    assign wr_mapped = wr_sel_ctrl | wr_sel_send | wr_sel_recall | wr_sel_high
        | (i_awaddr == conveyor_pkg::OFS_STATUS);
    assign clr_fault = wr_fire & wr_sel_ctrl & i_wstrb[0]
        & i_wdata[conveyor_pkg::CTRL_CLR_FAULT_BIT];

    assign status_word = {22'h0, auto_q, power_q, fault_q, hop_used_q,
        lvl.lim_truck, lvl.lim_car, lvl.lim_inside,
        o_motor_high, o_motor_run, state_q == ST_MOVE};

    always_comb begin
        rd_mapped = 1'b1;
        if (i_araddr == conveyor_pkg::OFS_CTRL) begin
            rd_word = {31'h0, ctrl_en_q};
        end else if (i_araddr == conveyor_pkg::OFS_SEND_SHIFT) begin
            rd_word = {16'h0, send_shift_q};
        end else if (i_araddr == conveyor_pkg::OFS_RECALL_SHIFT) begin
            rd_word = {16'h0, recall_shift_q};
        end else if (i_araddr == conveyor_pkg::OFS_HIGH_COUNT) begin
            rd_word = {16'h0, high_count_q};
        end else if (i_araddr == conveyor_pkg::OFS_STATUS) begin
            rd_word = status_word;
        end else begin
            rd_word = 32'h0;
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= conveyor_pkg::RESP_OKAY;
        end else begin
            o_awready <= wr_go;
            o_wready <= wr_go;
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_mapped ? conveyor_pkg::RESP_OKAY : conveyor_pkg::RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= conveyor_pkg::RESP_OKAY;
        end else begin
            o_arready <= rd_go;
            if (rd_fire) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= rd_mapped ? conveyor_pkg::RESP_OKAY : conveyor_pkg::RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_en_q <= conveyor_pkg::CTRL_ENABLE_RST;
            send_shift_q <= conveyor_pkg::SEND_SHIFT_RST;
            recall_shift_q <= conveyor_pkg::RECALL_SHIFT_RST;
            high_count_q <= conveyor_pkg::HIGH_COUNT_RST;
        end else if (wr_fire) begin
            if (wr_sel_ctrl && i_wstrb[0]) begin
                ctrl_en_q <= i_wdata[conveyor_pkg::CTRL_ENABLE_BIT];
            end else if (wr_sel_send) begin
                send_shift_q <= (send_shift_q & ~wmask[SW-1:0]) | (i_wdata[SW-1:0] & wmask[SW-1:0]);
            end else if (wr_sel_recall) begin
                recall_shift_q <= (recall_shift_q & ~wmask[SW-1:0])
                    | (i_wdata[SW-1:0] & wmask[SW-1:0]);
            end else if (wr_sel_high) begin
                high_count_q <= (high_count_q & ~wmask[SW-1:0]) | (i_wdata[SW-1:0] & wmask[SW-1:0]);
            end
        end
    end

    logic at_cust, run_ok, cmd_in, cmd_car, cmd_truck;
    logic can_in, can_car, can_truck, target_hit, time_up;
    logic [HW-1:0] shift_pt, high_len;
    logic rot_step;

    assign at_cust = lvl.lim_car | lvl.lim_truck;
    assign run_ok = power_q & ctrl_en_q; // see R17
    assign cmd_in = auto_q ? ~lvl.lim_inside : (rise.recall_btn | rise.cust_start); // see R15
    assign cmd_car = auto_q ? lvl.lim_inside : rise.car_btn;
    assign cmd_truck = ~auto_q & rise.truck_btn;
    assign can_in = cmd_in & ~lvl.lim_inside; // see R14
    assign can_car = cmd_car & ~lvl.lim_car & ~(at_cust & hop_used_q); // see R4
    assign can_truck = cmd_truck & ~lvl.lim_truck & ~(at_cust & hop_used_q); // see R4
    assign target_hit = (target_q == conveyor_pkg::DIR_IN && lvl.lim_inside) // see R1
        || (target_q == conveyor_pkg::DIR_CAR && lvl.lim_car) // see R2
        || (target_q == conveyor_pkg::DIR_TRUCK && lvl.lim_truck); // see R3
    assign time_up = (run_cnt_q >= RUN_LIMIT_CYCLES - 1'b1); // see R8
    assign shift_pt = (target_q == conveyor_pkg::DIR_IN) ? HW'(recall_shift_q) // see R5
        : HW'(send_shift_q);
    assign high_len = lvl.cfg_long ? {high_count_q, {conveyor_pkg::LONG_RANGE_SHIFT{1'b0}}} // see R7
        : HW'(high_count_q);
    assign rot_step = rise.rot_pulse & o_motor_run; // see R6

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        target_d = target_q;
        power_d = power_q;
        auto_d = auto_q;
        hop_used_d = hop_used_q;
        fault_d = clr_fault ? 1'b0 : fault_q;
        rot_cnt_d = rot_cnt_q;
        run_cnt_d = run_cnt_q;
        if (rise.power_btn) begin
            power_d = auto_q ? 1'b0 : ~power_q; // see R11 R17
            auto_d = 1'b0; // see R11
        end
        case (state_q)
            ST_STARTUP: begin
                if (strap_q == conveyor_pkg::STRAP_WAIT_CYC) begin
                    state_d = ST_IDLE;
                    auto_d = lvl.car_btn & lvl.truck_btn; // see R9 R10
                    power_d = lvl.car_btn & lvl.truck_btn;
                end
            end
            ST_IDLE: begin
                rot_cnt_d = '0;
                run_cnt_d = '0;
                phase_d = PH_LOW_PRE;
                if (run_ok && !rise.power_btn) begin
                    if (can_in) begin
                        state_d = ST_MOVE; // see R1
                        target_d = conveyor_pkg::DIR_IN;
                    end else if (can_car) begin
                        state_d = ST_MOVE; // see R2
                        target_d = conveyor_pkg::DIR_CAR;
                        hop_used_d = at_cust;
                    end else if (can_truck) begin
                        state_d = ST_MOVE; // see R3
                        target_d = conveyor_pkg::DIR_TRUCK;
                        hop_used_d = at_cust;
                    end
                end
            end
            default: begin
                run_cnt_d = run_cnt_q + 1'b1;
                if (rot_step) begin
                    rot_cnt_d = rot_cnt_q + 1'b1;
                end
                if (phase_q == PH_LOW_PRE && rot_step && rot_cnt_q + 1'b1 >= shift_pt) begin
                    phase_d = PH_HIGH; // see R20
                    rot_cnt_d = '0;
                end else if (phase_q == PH_HIGH && rot_step && rot_cnt_q + 1'b1 >= high_len) begin
                    phase_d = PH_LOW_POST; // see R20
                end
                if (target_hit) begin
                    state_d = ST_IDLE; // see R21
                    if (target_q == conveyor_pkg::DIR_IN) begin
                        hop_used_d = 1'b0; // see R4
                    end
                end else if (time_up) begin
                    state_d = ST_IDLE; // see R8
                    fault_d = 1'b1;
                end else if (!power_d || !ctrl_en_q) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_STARTUP;
            phase_q <= PH_LOW_PRE;
            target_q <= conveyor_pkg::DIR_NONE;
            power_q <= 1'b0;
            auto_q <= 1'b0;
            hop_used_q <= 1'b0;
            fault_q <= 1'b0;
            strap_q <= 3'h0;
            rot_cnt_q <= '0;
            run_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            target_q <= target_d;
            power_q <= power_d;
            auto_q <= auto_d;
            hop_used_q <= hop_used_d;
            fault_q <= fault_d;
            if (state_q == ST_STARTUP) begin
                strap_q <= strap_q + 3'h1;
            end
            rot_cnt_q <= rot_cnt_d;
            run_cnt_q <= run_cnt_d;
        end
    end

    // Drive and panel outputs, all registered
    logic moving_d;
    assign moving_d = (state_d == ST_MOVE);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_motor_run <= 1'b0;
            o_motor_high <= 1'b0;
            o_motor_dir_out <= 1'b0;
            o_brake_release <= 1'b0;
            o_ind <= '0;
        end else begin
            o_brake_release <= (power_d & moving_d) | lvl.brake_manual; // see R12
            o_motor_run <= moving_d & lvl.brake_ok; // see R19
            o_motor_high <= moving_d & lvl.brake_ok & (phase_d == PH_HIGH); // see R20
            o_motor_dir_out <= (target_d != conveyor_pkg::DIR_IN);
            o_ind.brake_manual_indicator <= lvl.brake_manual; // see R12
            o_ind.rotation_indicator <= lvl.rot_pulse; // see R18
            o_ind.truck_stop_limit_indicator <= lvl.lim_truck; // see R14
            o_ind.car_stop_limit_indicator <= lvl.lim_car; // see R14
            o_ind.inside_stop_limit_indicator <= lvl.lim_inside; // see R14
            o_ind.truck_send_indicator <= lvl.truck_btn; // see R16
            o_ind.car_send_indicator <= lvl.car_btn; // see R16
            o_ind.inward_request_indicator <= lvl.recall_btn | lvl.cust_start; // see R15
            o_ind.power_on_indicator <= power_d; // see R17
            o_ind.power_switch_indicator <= lvl.power_btn; // see R13
        end
    end
endmodule // carrier_conveyor_motion_control

//--- conveyor_properties.sv
// Port-level checks for the carrier conveyor controller
`timescale 1ns/100ps
module conveyor_properties #(
    parameter logic [conveyor_pkg::RUN_CNT_W-1:0] RUN_LIMIT_CYCLES = 2000
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire conveyor_pkg::panel_in_s i_panel,
    input wire conveyor_pkg::panel_ind_s o_ind,
    input wire logic o_motor_run,
    input wire logic o_motor_high,
    input wire logic o_motor_dir_out,
    input wire logic o_brake_release
);
    logic [2:0] up_q;
    logic [conveyor_pkg::RUN_CNT_W-1:0] run_q;
    wire up = (up_q == 3'h4);
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            up_q <= 3'h0;
            run_q <= '0;
        end else begin
            up_q <= up ? up_q : up_q + 3'h1;
            run_q <= o_motor_run ? run_q + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_pwr_sw;
        up |-> o_ind.power_switch_indicator == $past(i_panel.power_btn, 3);
    endproperty
    a_pwr_sw: assert property (p_pwr_sw) else $error("power switch lamp wrong");
    property p_limits;
        up |-> {o_ind.inside_stop_limit_indicator, o_ind.car_stop_limit_indicator,
            o_ind.truck_stop_limit_indicator} ==
            $past({i_panel.lim_inside, i_panel.lim_car, i_panel.lim_truck}, 3);
    endproperty
    a_limits: assert property (p_limits) else $error("limit lamps wrong");
    property p_inward;
        up |-> o_ind.inward_request_indicator ==
            $past(i_panel.recall_btn | i_panel.cust_start, 3);
    endproperty
    a_inward: assert property (p_inward) else $error("inward lamp wrong");
    property p_send;
        up |-> {o_ind.car_send_indicator, o_ind.truck_send_indicator} ==
            $past({i_panel.car_btn, i_panel.truck_btn}, 3);
    endproperty
    a_send: assert property (p_send) else $error("send lamps wrong");
    property p_rot; up |-> o_ind.rotation_indicator == $past(i_panel.rot_pulse, 3); endproperty
    a_rot: assert property (p_rot) else $error("rotation lamp");
    property p_manual;
        i_panel.brake_manual [*4] |-> o_brake_release && o_ind.brake_manual_indicator;
    endproperty
    a_manual: assert property (p_manual) else $error("manual release ignored");
    property p_run_brake; o_motor_run |-> o_brake_release; endproperty
    a_run_brake: assert property (p_run_brake) else $error("run on brake");
    property p_interlock; (!i_panel.brake_ok) [*5] |-> !o_motor_run; endproperty
    a_interlock: assert property (p_interlock) else $error("interlock");
    property p_start_low; $rose(o_motor_run) |-> !o_motor_high; endproperty
    a_start_low: assert property (p_start_low) else $error("began fast");
    property p_no_in;
        $rose(o_motor_run) && o_ind.inside_stop_limit_indicator |-> o_motor_dir_out;
    endproperty
    a_no_in: assert property (p_no_in) else $error("moved into inside limit");
    property p_in_stop;
        $rose(o_ind.inside_stop_limit_indicator) |-> ##[0:2] !o_motor_run;
    endproperty
    a_in_stop: assert property (p_in_stop) else $error("no stop at inside");
    property p_run_lim; run_q <= RUN_LIMIT_CYCLES; endproperty
    a_run_lim: assert property (p_run_lim) else $error("run limit");
    c_out: cover property (o_motor_run && o_motor_dir_out);
    c_in: cover property (o_motor_run && !o_motor_dir_out);
    c_high: cover property (o_motor_high);
endmodule // conveyor_properties

//--- conveyor_partner.sv
// Carrier, sprocket, stop switches and brake seen from the controller
`timescale 1ns/100ps
module conveyor_partner #(
    parameter int CAR_POS = 40,
    parameter int TRUCK_POS = 48
) (
    input wire logic i_clk_sys,
    input wire logic i_motor_run,
    input wire logic i_motor_dir_out,
    input wire logic i_brake_release,
    input wire logic i_stall,
    input wire logic i_brake_fail,
    output logic o_lim_inside,
    output logic o_lim_car,
    output logic o_lim_truck,
    output logic o_rot_pulse,
    output logic o_brake_ok,
    output int o_pos
);
    logic [3:0] ph_q = 4'h0;
    logic bok_q = 1'h0;
    int pos_q = 0;
    always @(posedge i_clk_sys) begin
        bok_q <= i_brake_release && !i_brake_fail;
        if (i_motor_run && !i_stall) begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == 4'hF) begin
                pos_q <= i_motor_dir_out ? pos_q + 1 : (pos_q > 0 ? pos_q - 1 : 0);
            end
        end
    end
    assign o_rot_pulse = ph_q[3];
    assign o_brake_ok = bok_q;
    assign o_pos = pos_q;
    assign o_lim_inside = (pos_q == 0);
    assign o_lim_car = (pos_q == CAR_POS);
    assign o_lim_truck = (pos_q == TRUCK_POS);
endmodule // conveyor_partner

//--- carrier_conveyor_motion_control_test.sv
// Self-checking bench for the carrier conveyor controller
`timescale 1ns/100ps
module carrier_conveyor_motion_control_test;
    localparam int PER = 16;
    localparam int RL = 2000;
    localparam int CAR = 40;
    localparam int TRUCK_SEND_INDICATOR = 48;
    logic i_clk_sys = 1'h0;
    logic i_nrst = 1'h0;
    logic [4:0] btn = 5'h0C;
    logic cfg = 1'h0, man = 1'h0, stall = 1'h0, bfail = 1'h0;
    logic lim_i, lim_c, lim_t, rot, bok, run, high, dout, brel;
    int pos;
    conveyor_pkg::panel_in_s panel;
    conveyor_pkg::panel_ind_s ind;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int num_errors = 0, n_tests = 0, cyc = 0, hi_cyc = 0, run_cyc = 0;
    assign panel = {cfg, bok, man, rot, lim_t, lim_c, lim_i, btn};
    always #4 i_clk_sys = ~i_clk_sys;
    carrier_conveyor_motion_control #(.RUN_LIMIT_CYCLES(conveyor_pkg::RUN_CNT_W'(RL))) dut_u (
        .i_clk_sys, .i_nrst, .i_panel(panel), .o_ind(ind),
        .o_motor_run(run), .o_motor_high(high), .o_motor_dir_out(dout),
        .o_brake_release(brel), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready));
    conveyor_partner #(.CAR_POS(CAR), .TRUCK_POS(TRUCK_SEND_INDICATOR)) far_u (
        .i_clk_sys, .i_motor_run(run), .i_motor_dir_out(dout),
        .i_brake_release(brel), .i_stall(stall), .i_brake_fail(bfail), .o_lim_inside(lim_i),
        .o_lim_car(lim_c), .o_lim_truck(lim_t), .o_rot_pulse(rot), .o_brake_ok(bok),
        .o_pos(pos));
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        hi_cyc <= (btn != 5'h00) ? 0 : hi_cyc + int'(high);
        run_cyc <= (btn != 5'h00) ? 0 : run_cyc + int'(run);
        if (cyc == 60000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic in_range(input int v, lo, hi, input string m);
        chk(32'(v >= lo && v <= hi), 32'h1, m);
    endtask
    task automatic wait_run(input logic v, input int lim);
        int n = 0;
        while (run !== v && n < lim) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(32'(run), 32'(v), "motor run state");
    endtask
    task automatic press(input int b);
        btn[b] <= 1'h1;
        repeat (12) @(posedge i_clk_sys);
        btn[b] <= 1'h0;
        @(posedge i_clk_sys);
    endtask
    task automatic idle_check(input int b);
        press(b);
        repeat (40) @(posedge i_clk_sys);
        chk(32'(run), 32'h0, "refused move ran");
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er = conveyor_pkg::RESP_OKAY);
        logic ad = 1'h0, wd = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge i_clk_sys);
            if (awvalid && awready) ad = 1'h1;
            if (wvalid && wready) wd = 1'h1;
            if (ad) awvalid <= 1'h0;
            if (wd) wvalid <= 1'h0;
        end
        do @(posedge i_clk_sys); while (!bvalid);
        chk(32'(bresp), 32'(er), "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
            input logic [1:0] er = conveyor_pkg::RESP_OKAY);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge i_clk_sys); while (!arready);
        arvalid <= 1'h0;
        do @(posedge i_clk_sys); while (!rvalid);
        chk(rdata, ed, "read data");
        chk(32'(rresp), 32'(er), "read response");
    endtask
    task automatic move(input int b, input logic d, input int at);
        press(b);
        wait_run(1'h1, 20);
        chk(32'(dout), 32'(d), "direction");
        wait_run(1'h0, RL);
        chk(pos, at, "stop position");
    endtask
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_nrst <= 1'h1;
        wait_run(1'h1, 200);
        chk(32'(ind.power_on_indicator & dout), 32'h1, "autocycle start");
        btn <= 5'h00;
        repeat (100) @(posedge i_clk_sys);
        press(4);
        wait_run(1'h0, 20);
        chk(32'(ind.power_on_indicator), 32'h0, "unit still on");
        idle_check(2);
        press(4);
        chk(32'(ind.power_on_indicator), 32'h1, "unit not on");
        axi_rd(conveyor_pkg::OFS_CTRL, 32'h1);
        axi_rd(conveyor_pkg::OFS_SEND_SHIFT, 32'h40);
        axi_rd(conveyor_pkg::OFS_RECALL_SHIFT, 32'h40);
        axi_rd(conveyor_pkg::OFS_HIGH_COUNT, 32'h80);
        axi_rd(8'h20, 32'h0, conveyor_pkg::RESP_SLVERR);
        axi_wr(8'h20, 32'h5, conveyor_pkg::RESP_SLVERR);
        axi_wr(conveyor_pkg::OFS_SEND_SHIFT, 32'h4);
        axi_wr(conveyor_pkg::OFS_RECALL_SHIFT, 32'h4);
        axi_wr(conveyor_pkg::OFS_HIGH_COUNT, 32'h8);
        axi_rd(conveyor_pkg::OFS_HIGH_COUNT, 32'h8);
        move(1, 1'h0, 0);
        idle_check(0);
        move(2, 1'h1, CAR);
        in_range(hi_cyc, 8 * PER - 24, 8 * PER + 24, "short high");
        cfg <= 1'h1;
        move(3, 1'h1, TRUCK_SEND_INDICATOR);
        idle_check(2);
        move(0, 1'h0, 0);
        in_range(hi_cyc, 32 * PER - 24, 32 * PER + 24, "long high");
        cfg <= 1'h0;
        stall <= 1'h1;
        press(2);
        wait_run(1'h1, 20);
        wait_run(1'h0, RL + 100);
        in_range(run_cyc, RL - 60, RL, "run limit");
        axi_rd(conveyor_pkg::OFS_STATUS, 32'h188);
        stall <= 1'h0;
        axi_wr(conveyor_pkg::OFS_CTRL, 32'h3);
        axi_rd(conveyor_pkg::OFS_STATUS, 32'h108);
        bfail <= 1'h1;
        idle_check(2);
        bfail <= 1'h0;
        wait_run(1'h1, 20);
        wait_run(1'h0, RL);
        chk(pos, CAR, "interlock stop");
        man <= 1'h1;
        repeat (6) @(posedge i_clk_sys);
        chk(32'(brel & ind.brake_manual_indicator), 32'h1, "manual release");
        man <= 1'h0;
        repeat (6) @(posedge i_clk_sys);
        chk(32'(brel), 32'h0, "brake held off");
        summarize();
    end
endmodule // carrier_conveyor_motion_control_test
bind carrier_conveyor_motion_control conveyor_properties #(
    .RUN_LIMIT_CYCLES(RUN_LIMIT_CYCLES)) props_u (
    .i_clk_sys, .i_nrst, .i_panel, .o_ind, .o_motor_run, .o_motor_high, .o_motor_dir_out,
    .o_brake_release);
